/* File: hdl/cef_pkg.sv */
// Constants, register map and field layout of the change-of-state event FIFO block
// Summary of operation
// RULE1: Status bit 0 set while FIFO empty
// RULE2: Status bit 3 set while FIFO full
// RULE3: Sticky overflow bit 11, write-one clears it
// RULE4: Word count in status bits 29-16, mirrored
// RULE5: Bit 30 level reached; bit 31 also enabled
// RULE6: Threshold interrupt is a level, not pulse
// RULE7: Threshold field bits 13-0, spare bits zero
// RULE8: Threshold register resets to zero
// RULE9: Count up per write, down per read
// RULE10: Host programs threshold before enabling interrupt
// RULE11: Count register bits 13-0, upper bits zero
// RULE12: Record is rising, falling, timestamp in order
// RULE13: Enabled transition stores record, clears held bits
// RULE14: Untriggered held edges ride the next record
// RULE15: Rising status bits held, write-one clears
// RULE16: Falling status bits held, write-one clears
// RULE17: Host clears setup events by writing ones
// RULE18: Preload register held, loaded on change-of-state tick
// RULE19: Timestamp counts each period, wraps at maximum
// RULE20: Preload reads return preload, not count
// RULE21: Count snapshot register sampled every core clock
// RULE22: Host disables counter before new preload
// RULE23: Change-of-state clock is selected reference divided ten
// RULE24: Control bit 11 enables threshold interrupt
// RULE25: Control bit 0 and reset clear FIFO
// RULE26: Empty FIFO read leaves count, pointer alone
package cef_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LVL_W = 14;
  localparam int unsigned MEM_AW = 12;
  localparam int unsigned MEM_DEPTH = 4096;
  localparam logic [LVL_W-1:0] FIFO_CAP = 14'h1000;
  localparam logic [3:0] CLK_DIV_LAST = 4'h9;

  localparam logic [ADDR_W-1:0] OFS_RISE_EN = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_FALL_EN = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_THRESH = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_WCOUNT = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_FIFO_RD = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_RISE_STAT = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_FALL_STAT = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_PRELOAD = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_SNAPSHOT = 8'h48;

  localparam int unsigned CTL_FIFO_RST = 0;
  localparam int unsigned CTL_ENABLE = 7;
  localparam int unsigned CTL_IRQ_EN = 11;
  localparam int unsigned CTL_CLK_SEL = 14;

  localparam int unsigned ST_EMPTY = 0;
  localparam int unsigned ST_FULL = 3;
  localparam int unsigned ST_OVF = 11;
  localparam int unsigned ST_LVL_LO = 16;
  localparam int unsigned ST_LVL_HI = 29;
  localparam int unsigned ST_THR_RAW = 30;
  localparam int unsigned ST_THR_MASKED = 31;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [LVL_W-1:0] THRESH_RST = 14'h0000;

  typedef enum logic [1:0] {
    CEF_REC_IDLE  = 2'b00,
    CEF_REC_RISE  = 2'b01,
    CEF_REC_FALL  = 2'b10,
    CEF_REC_STAMP = 2'b11
  } cef_rec_e;
endpackage

/* File: hdl/cef_event_capture.sv */
// Change-of-state capture engine with event FIFO, timestamp and register file
`timescale 1ns/1ns
module cef_event_capture (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_srst,
  input  wire logic [cef_pkg::ADDR_W-1:0] i_reg_addr,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  input  wire logic [cef_pkg::DATA_W-1:0] i_reg_wdata,
  output logic      [cef_pkg::DATA_W-1:0] o_reg_rdata,
  output logic                           o_reg_rvalid,
  input  wire logic                      i_osc_tick,
  input  wire logic                      i_pll_output_a_tick,
  input  wire logic [31:0]               i_io_upper,
  output logic                           o_fifo_level_threshold_irq
);
  localparam logic [1:0] BUF_FULL = 2'h2;

  logic [31:0]                rise_en_q;
  logic [31:0]                fall_en_q;
  logic                       fifo_rst_q;
  logic                       enable_q;
  logic                       irq_en_q;
  logic                       clk_sel_q;
  logic [cef_pkg::LVL_W-1:0]  thresh_q;
  logic [31:0]                preload_q;
  logic                       preload_pend_q;
  logic [31:0]                ts_q;
  logic [31:0]                snap_q;
  logic [3:0]                 div_q;
  logic                       tick_q;
  logic [31:0]                io_prev_q;
  logic [31:0]                acc_rise_q;
  logic [31:0]                acc_fall_q;
  logic [31:0]                rise_stat_q;
  logic [31:0]                fall_stat_q;
  logic [31:0]                rec_rise_q;
  logic [31:0]                rec_fall_q;
  logic [31:0]                rec_ts_q;
  cef_pkg::cef_rec_e          rec_state_q;
  logic [31:0]                mem [0:cef_pkg::MEM_DEPTH-1];
  logic [cef_pkg::MEM_AW-1:0] mem_wp_q;
  logic [cef_pkg::MEM_AW-1:0] mem_rp_q;
  logic [cef_pkg::MEM_AW:0]   mem_cnt_q;
  logic [31:0]                buf_q [0:1];
  logic                       buf_wp_q;
  logic                       buf_rp_q;
  logic [1:0]                 buf_occ_q;
  logic [cef_pkg::LVL_W-1:0]  level_q;
  logic                       ovf_q;

  logic        wr_hit;
  logic        rd_hit;
  logic        ref_tick;
  logic [31:0] rise_edges;
  logic [31:0] fall_edges;
  logic        trigger;
  logic        push_try;
  logic        push_ok;
  logic [31:0] push_word;
  logic        mem_pop;
  logic        host_pop;
  logic        fifo_clr;
  logic        fifo_full;
  logic        thr_raw;
  logic [31:0] stat_word;
  logic [31:0] wcnt_word;

  function automatic logic addr_is(input logic [cef_pkg::ADDR_W-1:0] a,
                                   input logic [cef_pkg::ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction

  assign wr_hit = i_reg_wr;
  assign rd_hit = i_reg_rd;
  assign fifo_clr = i_srst | fifo_rst_q; // RULE25
  assign fifo_full = (level_q == cef_pkg::FIFO_CAP); // RULE2
  assign thr_raw = (level_q >= thresh_q); // RULE5
  assign ref_tick = clk_sel_q ? i_pll_output_a_tick : i_osc_tick; // RULE23

  // Control and enables
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rise_en_q <= cef_pkg::ZERO_WORD;
      fall_en_q <= cef_pkg::ZERO_WORD;
      fifo_rst_q <= 1'b0;
      enable_q <= 1'b0;
      irq_en_q <= 1'b0;
      clk_sel_q <= 1'b0;
      thresh_q <= cef_pkg::THRESH_RST; // RULE8
    end else if (wr_hit) begin
      if (addr_is(i_reg_addr, cef_pkg::OFS_RISE_EN)) begin
        rise_en_q <= i_reg_wdata;
      end
      if (addr_is(i_reg_addr, cef_pkg::OFS_FALL_EN)) begin
        fall_en_q <= i_reg_wdata;
      end
      if (addr_is(i_reg_addr, cef_pkg::OFS_CTRL)) begin
        fifo_rst_q <= i_reg_wdata[cef_pkg::CTL_FIFO_RST]; // RULE25
        enable_q <= i_reg_wdata[cef_pkg::CTL_ENABLE];
        irq_en_q <= i_reg_wdata[cef_pkg::CTL_IRQ_EN]; // RULE24
        clk_sel_q <= i_reg_wdata[cef_pkg::CTL_CLK_SEL];
      end
      if (addr_is(i_reg_addr, cef_pkg::OFS_THRESH)) begin
        thresh_q <= i_reg_wdata[cef_pkg::LVL_W-1:0]; // RULE7
      end
    end
  end

  // Divide-by-ten of the selected reference gives the change-of-state tick
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      div_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (ref_tick) begin
        if (div_q == cef_pkg::CLK_DIV_LAST) begin
          div_q <= 4'h0;
          tick_q <= 1'b1; // RULE23
        end else begin
          div_q <= div_q + 4'h1;
        end
      end
    end
  end

  // Preload: a host write wins over a same-cycle load so no value is lost
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      preload_q <= cef_pkg::ZERO_WORD;
      preload_pend_q <= 1'b0;
    end else if (wr_hit && addr_is(i_reg_addr, cef_pkg::OFS_PRELOAD)) begin
      preload_q <= i_reg_wdata; // RULE18
      preload_pend_q <= 1'b1;
    end else if (tick_q) begin
      preload_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ts_q <= cef_pkg::ZERO_WORD;
    end else if (tick_q) begin
      if (preload_pend_q) begin
        ts_q <= preload_q; // RULE18
      end else if (enable_q) begin
        ts_q <= ts_q + 32'h0000_0001; // RULE19
      end
    end
  end

  // Snapshot lags the counter by one core cycle
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      snap_q <= cef_pkg::ZERO_WORD;
    end else begin
      snap_q <= ts_q; // RULE21
    end
  end

  // Edge detection on each tick; prev tracks even while disabled
  assign rise_edges = (tick_q && enable_q) ? (i_io_upper & ~io_prev_q) : cef_pkg::ZERO_WORD;
  assign fall_edges = (tick_q && enable_q) ? (~i_io_upper & io_prev_q) : cef_pkg::ZERO_WORD;
  // A busy serializer blocks the trigger; held edges stay accumulated
  assign trigger = (|(rise_edges & rise_en_q) || |(fall_edges & fall_en_q))
                   && (rec_state_q == cef_pkg::CEF_REC_IDLE); // RULE13

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      io_prev_q <= cef_pkg::ZERO_WORD;
    end else if (tick_q) begin
      io_prev_q <= i_io_upper;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      acc_rise_q <= cef_pkg::ZERO_WORD;
      acc_fall_q <= cef_pkg::ZERO_WORD;
    end else if (trigger) begin
      acc_rise_q <= cef_pkg::ZERO_WORD; // RULE13
      acc_fall_q <= cef_pkg::ZERO_WORD;
    end else begin
      acc_rise_q <= acc_rise_q | rise_edges; // RULE14
      acc_fall_q <= acc_fall_q | fall_edges;
    end
  end

  // Host-visible edge status, new edges win over a same-cycle clear
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rise_stat_q <= cef_pkg::ZERO_WORD;
      fall_stat_q <= cef_pkg::ZERO_WORD;
    end else begin
      if (wr_hit && addr_is(i_reg_addr, cef_pkg::OFS_RISE_STAT)) begin
        rise_stat_q <= (rise_stat_q & ~i_reg_wdata) | (rise_edges & rise_en_q); // RULE15
      end else begin
        rise_stat_q <= rise_stat_q | (rise_edges & rise_en_q);
      end
      if (wr_hit && addr_is(i_reg_addr, cef_pkg::OFS_FALL_STAT)) begin
        fall_stat_q <= (fall_stat_q & ~i_reg_wdata) | (fall_edges & fall_en_q); // RULE16
      end else begin
        fall_stat_q <= fall_stat_q | (fall_edges & fall_en_q);
      end
    end
  end

  // Record serializer: three consecutive pushes
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rec_state_q <= cef_pkg::CEF_REC_IDLE;
      rec_rise_q <= cef_pkg::ZERO_WORD;
      rec_fall_q <= cef_pkg::ZERO_WORD;
      rec_ts_q <= cef_pkg::ZERO_WORD;
    end else begin
      case (rec_state_q)
        cef_pkg::CEF_REC_IDLE: begin
          if (trigger) begin
            rec_rise_q <= acc_rise_q | rise_edges; // RULE14
            rec_fall_q <= acc_fall_q | fall_edges;
            rec_ts_q <= ts_q;
            rec_state_q <= cef_pkg::CEF_REC_RISE;
          end
        end
        cef_pkg::CEF_REC_RISE: rec_state_q <= cef_pkg::CEF_REC_FALL; // RULE12
        cef_pkg::CEF_REC_FALL: rec_state_q <= cef_pkg::CEF_REC_STAMP;
        cef_pkg::CEF_REC_STAMP: rec_state_q <= cef_pkg::CEF_REC_IDLE;
        default: rec_state_q <= cef_pkg::CEF_REC_IDLE;
      endcase
    end
  end

  always_comb begin
    case (rec_state_q)
      cef_pkg::CEF_REC_RISE: push_word = rec_rise_q;
      cef_pkg::CEF_REC_FALL: push_word = rec_fall_q;
      cef_pkg::CEF_REC_STAMP: push_word = rec_ts_q;
      default: push_word = cef_pkg::ZERO_WORD;
    endcase
  end

  assign push_try = (rec_state_q != cef_pkg::CEF_REC_IDLE);
  // Words offered while full are dropped; the overflow flag records it
  assign push_ok = push_try && !fifo_full && !fifo_rst_q;
  assign mem_pop = (mem_cnt_q != '0) && (buf_occ_q != BUF_FULL);
  assign host_pop = rd_hit && addr_is(i_reg_addr, cef_pkg::OFS_FIFO_RD)
                    && (buf_occ_q != 2'h0); // RULE26

  always_ff @(posedge i_core_clk) begin
    if (push_ok) begin
      mem[mem_wp_q] <= push_word;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (fifo_clr) begin
      mem_wp_q <= '0; // RULE25
      mem_rp_q <= '0;
      mem_cnt_q <= '0;
    end else begin
      if (push_ok) begin
        mem_wp_q <= mem_wp_q + 1'b1;
      end
      if (mem_pop) begin
        mem_rp_q <= mem_rp_q + 1'b1;
      end
      if (push_ok && !mem_pop) begin
        mem_cnt_q <= mem_cnt_q + 1'b1;
      end else if (!push_ok && mem_pop) begin
        mem_cnt_q <= mem_cnt_q - 1'b1;
      end
    end
  end

  // Two-entry output buffer decouples host reads from the array read path
  always_ff @(posedge i_core_clk) begin
    if (fifo_clr) begin
      buf_wp_q <= 1'b0;
      buf_rp_q <= 1'b0;
      buf_occ_q <= 2'h0;
    end else begin
      if (mem_pop) begin
        buf_wp_q <= ~buf_wp_q;
      end
      if (host_pop) begin
        buf_rp_q <= ~buf_rp_q;
      end
      if (mem_pop && !host_pop) begin
        buf_occ_q <= buf_occ_q + 2'h1;
      end else if (!mem_pop && host_pop) begin
        buf_occ_q <= buf_occ_q - 2'h1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (mem_pop) begin
      buf_q[buf_wp_q] <= mem[mem_rp_q];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (fifo_clr) begin
      level_q <= '0;
    end else if (push_ok && !host_pop) begin
      level_q <= level_q + 14'h0001; // RULE9
    end else if (!push_ok && host_pop) begin
      level_q <= level_q - 14'h0001;
    end
  end

  // Overflow is sticky; a new overflow beats a same-cycle clear
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ovf_q <= 1'b0;
    end else if (push_try && fifo_full) begin
      ovf_q <= 1'b1; // RULE3
    end else if (wr_hit && addr_is(i_reg_addr, cef_pkg::OFS_STATUS)
                 && i_reg_wdata[cef_pkg::ST_OVF]) begin
      ovf_q <= 1'b0;
    end
  end

  always_comb begin
    stat_word = cef_pkg::ZERO_WORD;
    stat_word[cef_pkg::ST_EMPTY] = (level_q == '0); // RULE1
    stat_word[cef_pkg::ST_FULL] = fifo_full; // RULE2
    stat_word[cef_pkg::ST_OVF] = ovf_q;
    stat_word[cef_pkg::ST_LVL_HI:cef_pkg::ST_LVL_LO] = level_q; // RULE4
    stat_word[cef_pkg::ST_THR_RAW] = thr_raw; // RULE5
    stat_word[cef_pkg::ST_THR_MASKED] = thr_raw && irq_en_q;
    wcnt_word = {18'h00000, level_q}; // RULE11
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_fifo_level_threshold_irq <= 1'b0;
    end else begin
      o_fifo_level_threshold_irq <= thr_raw && irq_en_q; // RULE6
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_reg_rdata <= cef_pkg::ZERO_WORD;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= rd_hit;
      if (rd_hit) begin
        case (i_reg_addr)
          cef_pkg::OFS_RISE_EN: o_reg_rdata <= rise_en_q;
          cef_pkg::OFS_FALL_EN: o_reg_rdata <= fall_en_q;
          cef_pkg::OFS_CTRL: o_reg_rdata <= {17'h00000, clk_sel_q, 2'h0, irq_en_q,
                                             3'h0, enable_q, 6'h00, fifo_rst_q};
          cef_pkg::OFS_STATUS: o_reg_rdata <= stat_word;
          cef_pkg::OFS_THRESH: o_reg_rdata <= {18'h00000, thresh_q}; // RULE7
          cef_pkg::OFS_WCOUNT: o_reg_rdata <= wcnt_word;
          cef_pkg::OFS_FIFO_RD: o_reg_rdata <= host_pop ? buf_q[buf_rp_q] : cef_pkg::ZERO_WORD;
          cef_pkg::OFS_RISE_STAT: o_reg_rdata <= rise_stat_q;
          cef_pkg::OFS_FALL_STAT: o_reg_rdata <= fall_stat_q;
          cef_pkg::OFS_PRELOAD: o_reg_rdata <= preload_q; // RULE20
          cef_pkg::OFS_SNAPSHOT: o_reg_rdata <= snap_q; // RULE21
          default: o_reg_rdata <= cef_pkg::ZERO_WORD;
        endcase
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  empty_flag_a: assert property (stat_word[0] == (level_q == 14'h0000)) // RULE1
    else $error("empty flag disagrees with level");
  full_flag_a: assert property (stat_word[3] == (level_q == 14'h1000)) // RULE2
    else $error("full flag disagrees with level");
  overflow_set_a: assert property (push_try && fifo_full |=> ovf_q) // RULE3
    else $error("overflow not latched");
  count_mirror_a: assert property (stat_word[29:16] == wcnt_word[13:0]) // RULE4
    else $error("status count differs from word count");
  thresh_mask_a: assert property (stat_word[31] == (stat_word[30] && irq_en_q)) // RULE5
    else $error("masked threshold flag wrong");
  irq_level_a: assert property (o_fifo_level_threshold_irq == $past(thr_raw && irq_en_q)) // RULE6
    else $error("threshold irq not following level");
  level_step_a: assert property (!fifo_clr && push_ok && !host_pop |=> level_q == $past(level_q) + 14'h0001) // RULE9
    else $error("level did not step up");
  record_order_a: assert property (trigger |=> push_try && push_word == $past(acc_rise_q | rise_edges)
                                    ##1 push_try ##1 push_try && push_word == $past(ts_q, 3)) // RULE12
    else $error("record words out of order");
  rise_w1c_a: assert property (wr_hit && i_reg_addr == 8'h3C && rise_edges == 32'h0000_0000
                               |=> (rise_stat_q & $past(i_reg_wdata)) == 32'h0000_0000) // RULE15
    else $error("rising status not cleared");
  ts_count_a: assert property (tick_q && enable_q && !preload_pend_q
                               |=> ts_q == $past(ts_q) + 32'h0000_0001) // RULE19
    else $error("timestamp did not advance");
  empty_read_a: assert property (rd_hit && i_reg_addr == 8'h38 && buf_occ_q == 2'h0 && !push_ok
                                 |=> level_q == $past(level_q) && buf_rp_q == $past(buf_rp_q)) // RULE26
    else $error("empty read moved fifo");

  record_cov_c: cover property (trigger ##3 push_ok);
  overflow_cov_c: cover property (push_try && fifo_full);
  irq_cov_c: cover property (o_fifo_level_threshold_irq ##1 !o_fifo_level_threshold_irq);
endmodule

/* File: tb/cef_line_model.sv */
// Far-side model: reference clock pulses and the upper input lines
`timescale 1ns/1ns
module cef_line_model (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_lines_want,
  output logic             o_osc_tick,
  output logic             o_pll_tick,
  output logic [31:0]      o_lines
);
  // Oscillator pulses every core cycle, PLL output A every other cycle
  initial begin
    o_osc_tick = 1'b1;
    o_pll_tick = 1'b0;
    o_lines = 32'h0000_0000;
  end
  // Non-blocking update on the rising edge avoids a race with the DUT sampling these outputs on the same edge
  always @(posedge i_clk) begin
    o_pll_tick <= ~o_pll_tick;
    o_lines <= i_lines_want;
  end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the change-of-state event capture block
`timescale 1ns/1ns
module tb;
  logic        clk;
  logic        srst;
  logic [7:0]  addr;
  logic        wr;
  logic        rd;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        rvalid;
  logic        osc_tick;
  logic        pll_tick;
  logic [31:0] lines;
  logic [31:0] lines_want;
  logic        irq;
  int          err_total;
  int          checks_done;
  int          cycles;
  logic [31:0] seed;
  logic [31:0] v;
  logic [31:0] t0;
  logic [31:0] rise_en;
  logic [31:0] fall_en;
  logic [31:0] rise_acc;
  logic [31:0] fall_acc;
  logic [31:0] rec [6];
  logic [13:0] thr;
  logic [13:0] nrec;
  logic        ien;
  int          i;

  cef_event_capture dut (
    .i_core_clk                 (clk),
    .i_srst                     (srst),
    .i_reg_addr                 (addr),
    .i_reg_wr                   (wr),
    .i_reg_rd                   (rd),
    .i_reg_wdata                (wdata),
    .o_reg_rdata                (rdata),
    .o_reg_rvalid               (rvalid),
    .i_osc_tick                 (osc_tick),
    .i_pll_output_a_tick        (pll_tick),
    .i_io_upper                 (lines),
    .o_fifo_level_threshold_irq (irq)
  );

  cef_line_model model (
    .i_clk        (clk),
    .i_lines_want (lines_want),
    .o_osc_tick   (osc_tick),
    .o_pll_tick   (pll_tick),
    .o_lines      (lines)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Run of about 15k cycles expected
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    while (rvalid !== 1'b1 && n < 3) begin
      @(negedge clk);
      n++;
    end
    d = rdata;
  endtask

  task automatic chkst(input logic [13:0] lvl, input logic ovf);
    logic [31:0] s;
    logic        r;
    r = (lvl >= thr);
    rreg(cef_pkg::OFS_STATUS, s);
    chk(s, {r & ien, r, lvl, 4'h0, ovf, 7'h00, lvl == cef_pkg::FIFO_CAP, 2'b00,
            lvl == 14'h0000});
    rreg(cef_pkg::OFS_WCOUNT, s);
    chk(s, {18'h00000, lvl});
    chk({31'h0, irq}, {31'h0, r & ien});
  endtask

  initial begin
    seed = 32'h0EB6_A105;
    srst = 1'b1;
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 32'h0;
    lines_want = 32'h0;
    err_total = 0;
    checks_done = 0;
    thr = 14'h0000;
    ien = 1'b0;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    chkst(14'h0000, 1'b0);
    rreg(cef_pkg::OFS_THRESH, v);
    chk(v, 32'h0);
    for (i = 0; i < 4; i++) begin
      t0 = $random(seed);
      wreg(cef_pkg::OFS_THRESH, {18'h00000, t0[13:0]});
      rreg(cef_pkg::OFS_THRESH, v);
      chk(v, {18'h00000, t0[13:0]});
      wreg(cef_pkg::OFS_PRELOAD, t0);
      rreg(cef_pkg::OFS_PRELOAD, v);
      chk(v, t0);
    end
    // Preload just below rollover, then let a few ticks pass
    wreg(cef_pkg::OFS_PRELOAD, 32'hFFFF_FFFE);
    wreg(cef_pkg::OFS_CTRL, 32'h0000_0080);
    repeat (40) @(negedge clk);
    rreg(cef_pkg::OFS_SNAPSHOT, v);
    chk({31'h0, v < 32'h4}, 32'h1);
    rreg(cef_pkg::OFS_SNAPSHOT, t0);
    repeat (200) @(negedge clk);
    rreg(cef_pkg::OFS_SNAPSHOT, v);
    chk({31'h0, (v - t0) inside {[32'd19:32'd21]}}, 32'h1);
    wreg(cef_pkg::OFS_CTRL, 32'h0000_4080);
    rreg(cef_pkg::OFS_SNAPSHOT, t0);
    repeat (200) @(negedge clk);
    rreg(cef_pkg::OFS_SNAPSHOT, v);
    chk({31'h0, (v - t0) inside {[32'd9:32'd11]}}, 32'h1);
    // Held edge on an unenabled line rides the next triggered record
    wreg(cef_pkg::OFS_RISE_EN, 32'h1);
    wreg(cef_pkg::OFS_FALL_EN, 32'h0);
    wreg(cef_pkg::OFS_THRESH, 32'h3);
    thr = 14'h0003;
    ien = 1'b1;
    wreg(cef_pkg::OFS_CTRL, 32'h0000_0880);
    wreg(cef_pkg::OFS_RISE_STAT, 32'hFFFF_FFFF);
    wreg(cef_pkg::OFS_FALL_STAT, 32'hFFFF_FFFF);
    lines_want = 32'h20;
    repeat (40) @(negedge clk);
    chkst(14'h0000, 1'b0);
    lines_want = 32'h21;
    repeat (40) @(negedge clk);
    lines_want = 32'h00;
    repeat (40) @(negedge clk);
    lines_want = 32'h01;
    repeat (40) @(negedge clk);
    chkst(14'h0006, 1'b0);
    for (i = 0; i < 6; i++) begin
      rreg(cef_pkg::OFS_FIFO_RD, rec[i]);
    end
    chk(rec[0], 32'h21);
    chk(rec[1], 32'h00);
    chk(rec[3], 32'h01);
    chk(rec[4], 32'h21);
    chk(rec[5] - rec[2], 32'h8);
    rreg(cef_pkg::OFS_FIFO_RD, v);
    chkst(14'h0000, 1'b0);
    rreg(cef_pkg::OFS_RISE_STAT, v);
    chk(v, 32'h1);
    wreg(cef_pkg::OFS_RISE_STAT, 32'h0);
    rreg(cef_pkg::OFS_RISE_STAT, v);
    chk(v, 32'h1);
    wreg(cef_pkg::OFS_RISE_STAT, v);
    rreg(cef_pkg::OFS_RISE_STAT, v);
    chk(v, 32'h0);
    // Random lines and enables; 12-cycle spacing keeps one change per tick
    rise_en = $random(seed);
    fall_en = $random(seed);
    wreg(cef_pkg::OFS_RISE_EN, rise_en);
    wreg(cef_pkg::OFS_FALL_EN, fall_en);
    rise_acc = 32'h0;
    fall_acc = 32'h0;
    nrec = 14'h0000;
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      t0 = (~lines_want & v & rise_en) | (lines_want & ~v & fall_en);
      rise_acc = rise_acc | (~lines_want & v & rise_en);
      fall_acc = fall_acc | (lines_want & ~v & fall_en);
      nrec = nrec + ((t0 != 32'h0) ? 14'h0003 : 14'h0000);
      lines_want = v;
      repeat (12) @(negedge clk);
    end
    repeat (30) @(negedge clk);
    chkst(nrec, 1'b0);
    rreg(cef_pkg::OFS_RISE_STAT, v);
    chk(v, rise_acc);
    rreg(cef_pkg::OFS_FALL_STAT, v);
    chk(v, fall_acc);
    wreg(cef_pkg::OFS_FALL_STAT, v);
    rreg(cef_pkg::OFS_FALL_STAT, v);
    chk(v, 32'h0);
    wreg(cef_pkg::OFS_CTRL, 32'h0000_0881);
    wreg(cef_pkg::OFS_CTRL, 32'h0000_0880);
    chkst(14'h0000, 1'b0);
    // Fill past capacity with one record per tick
    wreg(cef_pkg::OFS_RISE_EN, 32'h1);
    wreg(cef_pkg::OFS_FALL_EN, 32'h1);
    for (i = 0; i < 1366; i++) begin
      lines_want = lines_want ^ 32'h1;
      repeat (10) @(negedge clk);
    end
    repeat (40) @(negedge clk);
    chkst(cef_pkg::FIFO_CAP, 1'b1);
    wreg(cef_pkg::OFS_STATUS, 32'h0000_0800);
    chkst(cef_pkg::FIFO_CAP, 1'b0);
    wreg(cef_pkg::OFS_CTRL, 32'h0000_0081);
    wreg(cef_pkg::OFS_CTRL, 32'h0000_0080);
    ien = 1'b0;
    chkst(14'h0000, 1'b0);
    end_sim();
  end
endmodule
